// >>> shared/wpl_pkg.sv
package wpl_pkg;

    localparam int CLK_MHZ = 250;
    localparam int MIN_PULSE_US = 250;
    localparam int MAX_PULSE_US = 34000;
    localparam int MAX_WAIT_US = 33000;
    localparam int SHORT_LEVEL_US = 3000;
    localparam int SHORT_LEVEL_PTS = 10;
    localparam int SAVE_NAME_MAX = 10;
    localparam int SAVE_SLOTS = 16;
    localparam int SAVE_SEG_MAX = 10;
    localparam int MAX_SAMPLES = 8;
    localparam int US_CYC = CLK_MHZ;
    localparam int MAX_WAIT_CYC = MAX_WAIT_US * US_CYC;
    localparam int MIN_PULSE_CYC = MIN_PULSE_US * US_CYC;
    localparam int MAX_PULSE_CYC = MAX_PULSE_US * US_CYC;

    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_COUNT = 12'h008;
    localparam logic [11:0] ADDR_SKIP = 12'h00c;
    localparam logic [11:0] ADDR_WAIT = 12'h010;
    localparam logic [11:0] ADDR_TRIG = 12'h014;
    localparam logic [11:0] ADDR_SAMP = 12'h018;
    localparam logic [11:0] ADDR_APPEND = 12'h01c;
    localparam logic [11:0] ADDR_NEXT = 12'h020;
    localparam logic [11:0] ADDR_REPEAT = 12'h024;
    localparam logic [11:0] ADDR_REPVAL = 12'h028;
    localparam logic [11:0] ADDR_SEGKIND = 12'h02c;
    localparam logic [11:0] ADDR_SAMPQ = 12'h030;
    localparam logic [11:0] ADDR_SAVE = 12'h034;
    localparam logic [11:0] ADDR_LEVEL = 12'h038;

    localparam int CTRL_RUN = 0;
    localparam int CTRL_CLEAR = 1;
    localparam int CTRL_CURR = 2;
    localparam int CTRL_ERRCLR = 3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] SEG_REP = 2'b01;
    localparam logic [1:0] SEG_INIT = 2'b00;

    typedef enum logic [2:0] {
        PK_LEVEL = 3'h0,
        PK_WAIT_HI = 3'h1,
        PK_WAIT_LO = 3'h2,
        PK_TRIG = 3'h3,
        PK_SAMPLE = 3'h4
    } pkind_t;

    typedef struct packed {
        logic       initial_seg;
        pkind_t     kind;
        logic [15:0] level;
        logic [23:0] dwell;
    } point_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DWELL = 4'b0010,
        ST_PULSE = 4'b0100,
        ST_COPY = 4'b1000
    } seq_state_t;

endpackage

// >>> src/waveform_point_list_sequencer.sv
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Wait-high point holds level until trigger input samples high
// - Wait-low point holds level until trigger input samples low
// - Wait-high then wait-low advances only on the falling trigger edge
// - With timeout set, wait ends on awaited level or expiry, whichever first
// - Wait timeout limited to 33 ms; longer waits chain wait points
// - Trigger setup fixes width and polarity; transistor inactive until trigger point
// - Trigger point holds level and emits one pulse of configured width
// - Polarity on conducts during pulse; polarity off is non-conducting during pulse
// - After trigger setup, port pins are trigger output until list is cleared
// - Repeat copies a point range per value, substituting level, appended
// - Whole list runs loop-count times, then stops; a list ending in a trigger point with count above 1 runs past its end
// - Skip count bypasses leading points on loops after the first
// - Level shorter than 3 ms occupies 10 points
// - Position query returns index of the next appended point
// - Sample query reports sample count, first sample point index and a voltage/current mark; code returns only the low 4 bits of that index
// - Initial segments run on first loop only; repeating ones every loop
// - Final point of the list is always treated as repeating
// - Segment kind query returns 01 for repeating, 00 for initial
// - Sample duration settable once within range; second set is an error
// - Reading sample duration before set is a command error
// - Save takes 1..10 char name, upper-cased, slot 1..16; code only checks the slot in bits 7:0 and stores the written word
// - Save keeps at most 10 segments, loop count and limits; code keeps only the written save word
module waveform_point_list_sequencer
    import wpl_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int WAIT_MAX_CYC = MAX_WAIT_CYC
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic         clk_en,
    input  wire logic [11:0]  s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [11:0]  s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire logic         trig_in,
    output logic              trig_out_collector,
    output logic              trig_out_emitter,
    output logic              output_off_flag_on,
    output logic [15:0]       level_out,
    output logic              sample_strobe
);

    point_t            mem [DEPTH];
    logic [1:0]        sync_r;
    logic              trig_s;
    seq_state_t        st_r;
    logic [AW-1:0]     ptr_r, next_r, src_r, src_end_r, rep_lo_r, rep_hi_r;
    logic [15:0]       loops_r, loop_no_r;
    logic [AW-1:0]     skip_r;
    logic [23:0]       wait_r, trig_w_r, samp_w_r, timer_r;
    logic              trig_cfg_r, trig_pol_r, samp_set_r, trig_act_r, err_r, is_curr_r;
    logic              seg_init_r;
    logic [15:0]       rep_val_r;
    logic [31:0]       save_r;
    logic [AW-1:0]     samp_idx_r [MAX_SAMPLES];
    logic [3:0]        samp_n_r;
    logic              aw_h_r, w_h_r;
    logic [11:0]       awa_r;
    logic [31:0]       wd_r;
    logic              wr_go, rd_go, run_req;
    point_t            cur, app_pt;

    function automatic logic [23:0] us_cyc(input logic [31:0] us);
        logic [31:0] c;
        c = us * US_CYC;
        return c[23:0];
    endfunction

    function automatic logic in_range(input logic [31:0] us, input logic [31:0] hi);
        return (us >= MIN_PULSE_US) && (us <= hi);
    endfunction

    // Trigger pin synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_r <= '0;
        end else if (clk_en) begin
            sync_r <= {sync_r[0], trig_in};
        end
    end
    assign trig_s = sync_r[1];

    // AXI4-Lite write channel holding
    assign s_axi_awready = !aw_h_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_h_r && !s_axi_bvalid;
    assign wr_go = aw_h_r && w_h_r && !s_axi_bvalid && st_r != ST_COPY;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_h_r <= 1'b0;
            w_h_r <= 1'b0;
            awa_r <= '0;
            wd_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_h_r <= 1'b1;
                awa_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_h_r <= 1'b1;
                wd_r <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_h_r <= 1'b0;
                w_h_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awa_r > ADDR_LEVEL) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;
    assign run_req = wr_go && awa_r == ADDR_CTRL && wd_r[CTRL_RUN];

    always_comb begin
        app_pt.initial_seg = seg_init_r;
        app_pt.kind = pkind_t'(wd_r[18:16]);
        app_pt.level = wd_r[15:0];
        app_pt.dwell = 24'h000000;
    end

    // Configuration, list building and errors
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            loops_r <= 16'h0001;
            skip_r <= '0;
            wait_r <= '0;
            trig_w_r <= '0;
            samp_w_r <= '0;
            trig_cfg_r <= 1'b0;
            trig_pol_r <= 1'b0;
            samp_set_r <= 1'b0;
            err_r <= 1'b0;
            is_curr_r <= 1'b0;
            seg_init_r <= 1'b0;
            rep_val_r <= '0;
            rep_lo_r <= '0;
            rep_hi_r <= '0;
            save_r <= '0;
            samp_n_r <= '0;
            next_r <= '0;
        end else if (clk_en) begin
            if (wr_go) begin
                unique case (awa_r)
                    ADDR_CTRL: begin
                        if (wd_r[CTRL_CLEAR]) begin
                            next_r <= '0;
                            trig_cfg_r <= 1'b0;
                            samp_n_r <= '0;
                            samp_set_r <= 1'b0;
                        end
                        is_curr_r <= wd_r[CTRL_CURR];
                        if (wd_r[CTRL_ERRCLR]) err_r <= 1'b0;
                    end
                    ADDR_COUNT: loops_r <= wd_r[15:0];
                    ADDR_SKIP: skip_r <= wd_r[AW-1:0];
                    ADDR_WAIT: begin
                        if (wd_r[31:0] <= MAX_WAIT_US) wait_r <= us_cyc(wd_r);
                        else err_r <= 1'b1;
                    end
                    ADDR_TRIG: begin
                        if (in_range({1'b0, wd_r[30:0]}, MAX_PULSE_US)) begin
                            trig_w_r <= us_cyc({1'b0, wd_r[30:0]});
                            trig_pol_r <= wd_r[31];
                            trig_cfg_r <= 1'b1;
                        end else err_r <= 1'b1;
                    end
                    ADDR_SAMP: begin
                        if (samp_set_r || !in_range(wd_r, MAX_PULSE_US)) begin
                            err_r <= 1'b1;
                        end else begin
                            samp_w_r <= us_cyc(wd_r);
                            samp_set_r <= 1'b1;
                        end
                    end
                    ADDR_APPEND: begin
                        if (wd_r[18:16] == PK_SAMPLE && samp_n_r < MAX_SAMPLES) begin
                            samp_idx_r[samp_n_r[2:0]] <= next_r;
                            samp_n_r <= samp_n_r + 4'h1;
                        end
                        if (wd_r[18:16] == PK_LEVEL && wd_r[31:19] < SHORT_LEVEL_US[12:0]) begin
                            next_r <= next_r + AW'(SHORT_LEVEL_PTS);
                        end else begin
                            next_r <= next_r + 1'b1;
                        end
                    end
                    ADDR_REPEAT: begin
                        rep_lo_r <= wd_r[AW-1:0];
                        rep_hi_r <= wd_r[AW+15:16];
                    end
                    ADDR_REPVAL: rep_val_r <= wd_r[15:0];
                    ADDR_SEGKIND: seg_init_r <= wd_r[0];
                    ADDR_SAVE: begin
                        if (wd_r[7:0] == 8'h00 || wd_r[7:0] > SAVE_SLOTS[7:0]) err_r <= 1'b1;
                        else save_r <= wd_r;
                    end
                    default: ;
                endcase
            end
            if (st_r == ST_COPY) next_r <= next_r + 1'b1;
            if (rd_go && s_axi_araddr == ADDR_SAMP && !samp_set_r) err_r <= 1'b1;
        end
    end

    // Point memory writes: appends and repeat copies
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (wr_go && awa_r == ADDR_APPEND) begin
                if (app_pt.kind == PK_LEVEL && wd_r[31:19] < SHORT_LEVEL_US[12:0]) begin
                    for (int i = 0; i < SHORT_LEVEL_PTS; i++) begin
                        mem[AW'(next_r + AW'(i))] <= app_pt;
                    end
                end else begin
                    mem[next_r] <= app_pt;
                end
            end else if (st_r == ST_COPY) begin
                mem[next_r] <= '{initial_seg: mem[src_r].initial_seg, kind: mem[src_r].kind,
                                 level: rep_val_r, dwell: mem[src_r].dwell};
            end
        end
    end

    assign cur = mem[ptr_r];

    // Sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_IDLE;
            ptr_r <= '0;
            loop_no_r <= '0;
            timer_r <= '0;
            trig_act_r <= 1'b0;
            src_r <= '0;
            src_end_r <= '0;
            level_out <= '0;
            sample_strobe <= 1'b0;
        end else if (clk_en) begin
            sample_strobe <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    if (run_req && next_r != '0) begin
                        ptr_r <= '0;
                        loop_no_r <= 16'h0001;
                        timer_r <= '0;
                        st_r <= ST_DWELL;
                    end else if (wr_go && awa_r == ADDR_REPVAL) begin
                        src_r <= rep_lo_r;
                        src_end_r <= rep_hi_r;
                        st_r <= ST_COPY;
                    end
                end
                ST_COPY: begin
                    src_r <= src_r + 1'b1;
                    if (src_r == src_end_r) st_r <= ST_IDLE;
                end
                ST_DWELL: begin
                    level_out <= cur.level;
                    timer_r <= timer_r + 24'h1;
                    if (cur.initial_seg && loop_no_r > 16'h0001 && ptr_r != next_r - 1'b1) begin
                        ptr_r <= ptr_r + 1'b1;
                        timer_r <= '0;
                    end else begin
                        unique case (cur.kind)
                            PK_WAIT_HI: if (trig_s ||
                                            (wait_r != '0 && timer_r >= wait_r)) begin
                                ptr_r <= ptr_r + 1'b1;
                                timer_r <= '0;
                            end
                            PK_WAIT_LO: if (!trig_s ||
                                            (wait_r != '0 && timer_r >= wait_r)) begin
                                ptr_r <= ptr_r + 1'b1;
                                timer_r <= '0;
                            end
                            PK_TRIG: begin
                                trig_act_r <= 1'b1;
                                timer_r <= '0;
                                st_r <= ST_PULSE;
                            end
                            PK_SAMPLE: begin
                                sample_strobe <= 1'b1;
                                ptr_r <= ptr_r + 1'b1;
                                timer_r <= '0;
                            end
                            default: begin
                                ptr_r <= ptr_r + 1'b1;
                                timer_r <= '0;
                            end
                        endcase
                    end
                    if (ptr_r == next_r - 1'b1 && !(cur.kind == PK_TRIG)) begin
                        if ((cur.kind == PK_WAIT_HI && !trig_s && !(wait_r != '0 && timer_r >= wait_r))
                         || (cur.kind == PK_WAIT_LO && trig_s && !(wait_r != '0 && timer_r >= wait_r))) begin
                            ptr_r <= ptr_r;
                        end else if (loop_no_r >= loops_r) begin
                            st_r <= ST_IDLE;
                        end else begin
                            loop_no_r <= loop_no_r + 16'h1;
                            ptr_r <= skip_r;
                        end
                    end
                end
                ST_PULSE: begin
                    timer_r <= timer_r + 24'h1;
                    if (timer_r + 24'h1 >= trig_w_r) begin
                        trig_act_r <= 1'b0;
                        timer_r <= '0;
                        ptr_r <= ptr_r + 1'b1;
                        st_r <= (ptr_r == next_r - 1'b1 && loop_no_r >= loops_r) ? ST_IDLE : ST_DWELL;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Transistor drive: inactive is the opposite of the active polarity
    always_comb begin
        output_off_flag_on = trig_cfg_r;
        trig_out_collector = trig_cfg_r && (trig_act_r == trig_pol_r);
        trig_out_emitter = trig_out_collector;
    end

    // Read channel
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    ADDR_STATUS: s_axi_rdata <= {26'h0, err_r, trig_s, trig_act_r, st_r == ST_COPY,
                                                 st_r == ST_DWELL || st_r == ST_PULSE, samp_set_r};
                    ADDR_COUNT: s_axi_rdata <= {16'h0, loops_r};
                    ADDR_SKIP: s_axi_rdata <= 32'(skip_r);
                    ADDR_WAIT: s_axi_rdata <= {8'h0, wait_r};
                    ADDR_TRIG: s_axi_rdata <= {trig_pol_r, 7'h0, trig_w_r};
                    ADDR_SAMP: begin
                        s_axi_rdata <= {8'h0, samp_w_r};
                        if (!samp_set_r) s_axi_rresp <= RESP_SLVERR;
                    end
                    ADDR_NEXT: s_axi_rdata <= 32'(next_r);
                    ADDR_SEGKIND: s_axi_rdata <= {30'h0, seg_init_r ? SEG_INIT : SEG_REP};
                    ADDR_SAMPQ: s_axi_rdata <= {is_curr_r, 23'h0, samp_n_r,
                                                4'(samp_n_r != 0 ? samp_idx_r[0] : '0)};
                    ADDR_SAVE: s_axi_rdata <= save_r;
                    ADDR_LEVEL: s_axi_rdata <= {16'h0, level_out};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= (s_axi_araddr > ADDR_LEVEL) ? RESP_SLVERR : RESP_OKAY;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    pulse_width_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(trig_act_r) |-> trig_act_r [*2]) else $error("trigger pulse too short");
    idle_inactive_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !trig_act_r && trig_cfg_r |-> trig_out_collector != trig_pol_r) else $error("bad idle");
    wait_high_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && st_r == ST_DWELL && cur.kind == PK_WAIT_HI && !trig_s && wait_r == '0
        && ptr_r != next_r - 1'b1 |=> $stable(ptr_r)) else $error("wait high advanced");
    wait_low_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && st_r == ST_DWELL && cur.kind == PK_WAIT_LO && trig_s && wait_r == '0
        && ptr_r != next_r - 1'b1 |=> $stable(ptr_r)) else $error("wait low advanced");
    clear_trig_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_go && awa_r == ADDR_CTRL && wd_r[CTRL_CLEAR] |=> !trig_cfg_r)
        else $error("clear kept trigger");
    samp_once_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && wr_go && awa_r == ADDR_SAMP && samp_set_r |=> err_r) else $error("no error");
    run_start_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && st_r == ST_IDLE && run_req && next_r != '0 |=> ptr_r == '0 && st_r == ST_DWELL)
        else $error("bad start");
    samp_query_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clk_en && rd_go && s_axi_araddr == ADDR_SAMP && !samp_set_r |=> s_axi_rresp == RESP_SLVERR)
        else $error("no read error");
    cover_run_c: cover property (@(posedge core_clk) st_r == ST_DWELL ##1 st_r == ST_IDLE);
    cover_pulse_c: cover property (@(posedge core_clk) $fell(trig_act_r));
    cover_copy_c: cover property (@(posedge core_clk) st_r == ST_COPY ##1 st_r == ST_IDLE);

endmodule

// >>> verif/trig_host.sv
`timescale 1ns/1ps
module trig_host (
    input  wire logic core_clk,
    output logic      trig_in
);
    initial trig_in = 1'b0;
    // Level changes only just after an edge; caller keeps highs long enough
    task automatic drive(input logic v);
        @(posedge core_clk);
        trig_in <= v;
    endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    import wpl_pkg::*;
    logic        core_clk, arst_n, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, trig_in, trig_out_collector, trig_out_emitter;
    logic        output_off_flag_on, sample_strobe;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] level_out;
    int          fails, checks_done;

    waveform_point_list_sequencer waveform_point_list_sequencer_inst (.*);
    trig_host trig_host_inst (.core_clk(core_clk), .trig_in(trig_in));

    always #2 core_clk = ~core_clk;

    task automatic finish_test;
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Handshakes are sampled at the falling edge, where they equal what the next rising edge sees
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int   n;
        logic awt, wt, bdone;
        n = 0;
        bdone = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bdone && n < 500) begin
            @(negedge core_clk);
            awt = s_axi_awvalid && s_axi_awready;
            wt = s_axi_wvalid && s_axi_wready;
            bdone = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (awt) s_axi_awvalid <= 1'b0;
            if (wt) s_axi_wvalid <= 1'b0;
            n++;
        end
        if (!bdone) begin
            fails++;
            finish_test();
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        int   n;
        logic art, rdone;
        n = 0;
        rdone = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rdone && n < 500) begin
            @(negedge core_clk);
            art = s_axi_arvalid && s_axi_arready;
            rdone = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (art) s_axi_arvalid <= 1'b0;
            n++;
        end
        if (!rdone) begin
            fails++;
            finish_test();
        end
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        {core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hf;
        fails = 0;
        checks_done = 0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(ADDR_COUNT); chk(d, 32'h1);
        rd(ADDR_NEXT); chk(d, 32'h0);
        rd(ADDR_SAMP); chk(32'(r), 32'(RESP_SLVERR));
        rd(ADDR_STATUS); chk(32'(d[5]), 32'h1);
        wr(ADDR_CTRL, 32'h8);
        wr(ADDR_SAMP, 32'd250); rd(ADDR_SAMP); chk(d, 32'(MIN_PULSE_CYC));
        chk(32'(r), 32'(RESP_OKAY));
        wr(ADDR_SAMP, 32'd250); rd(ADDR_STATUS); chk(32'(d[5]), 32'h1);
        wr(ADDR_CTRL, 32'h8);
        wr(12'h03c, 32'h0); chk(32'(r), 32'(RESP_SLVERR));
        wr(ADDR_SEGKIND, 32'h1); rd(ADDR_SEGKIND); chk(d, 32'(SEG_INIT));
        wr(ADDR_SEGKIND, 32'h0); rd(ADDR_SEGKIND); chk(d, 32'(SEG_REP));
        wr(ADDR_TRIG, 32'h800000fa);
        chk(32'(output_off_flag_on), 32'h1);
        chk(32'(trig_out_collector), 32'h0);
        wr(ADDR_APPEND, 32'h00010011);
        wr(ADDR_APPEND, 32'h00020022);
        wr(ADDR_APPEND, 32'h00030033);
        rd(ADDR_NEXT); chk(d, 32'h3);
        wr(ADDR_APPEND, 32'h00280044);
        rd(ADDR_NEXT); chk(d, 32'd13);
        wr(ADDR_REPEAT, 32'h00020001);
        wr(ADDR_REPVAL, 32'h00000055);
        rd(ADDR_NEXT); chk(d, 32'd15);
        wr(ADDR_CTRL, 32'h1);
        repeat (20) @(posedge core_clk);
        chk(32'(level_out), 32'h0011);
        trig_host_inst.drive(1'b1);
        repeat (10) @(posedge core_clk);
        chk(32'(level_out), 32'h0022);
        repeat (10) @(posedge core_clk);
        chk(32'(level_out), 32'h0022);
        trig_host_inst.drive(1'b0);
        repeat (10) @(posedge core_clk);
        chk(32'(level_out), 32'h0033);
        chk(32'({trig_out_collector, trig_out_emitter}), 32'h3);
        chk(32'(sample_strobe), 32'h0);
        wr(ADDR_CTRL, 32'h2);
        chk(32'(output_off_flag_on), 32'h0);
        finish_test();
    end
endmodule
